/* pkg/flr_pkg.sv */
// Constants of the flash LED control register set.
// Assumes a 20 MHz clock; times are in ns and converted to cycles here.
package flr_pkg;
  // Clock
  localparam int CLK_PERIOD_NS = 50;
  // Serial control pin low time before shutdown
  localparam int SHUTDOWN_TIME_NS = 405000;
  localparam int SHUTDOWN_CYCLES = (SHUTDOWN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Safety timer step, 156.25 ms
  localparam int SAFETY_STEP_NS = 156250000;
  localparam int SAFETY_STEP_CYCLES = SAFETY_STEP_NS / CLK_PERIOD_NS;
  // Register addresses
  localparam logic [2:0] ADDR_FLASH_CONTROL = 3'h1;
  localparam logic [2:0] ADDR_TORCH_CONTROL = 3'h2;
  localparam logic [2:0] ADDR_SAFETY_DURATION = 3'h3;
  localparam logic [2:0] ADDR_BATTERY_THRESHOLD = 3'h4;
  localparam logic [2:0] ADDR_SAFETY_CURRENT_THRESHOLD = 3'h5;
  // Largest accepted data per register
  localparam logic [4:0] MAX_FLASH_CONTROL = 5'h1f;
  localparam logic [4:0] MAX_TORCH_CONTROL = 5'h1f;
  localparam logic [4:0] MAX_SAFETY_DURATION = 5'h07;
  localparam logic [4:0] MAX_BATTERY_THRESHOLD = 5'h09;
  localparam logic [4:0] MAX_SAFETY_CURRENT_THRESHOLD = 5'h05;
  // Values after reset and shutdown
  localparam logic [4:0] RST_FLASH_CONTROL = 5'h00;
  localparam logic [4:0] RST_TORCH_CONTROL = 5'h00;
  localparam logic [2:0] RST_SAFETY_DURATION = 3'h7;
  localparam logic [3:0] RST_BATTERY_THRESHOLD = 4'h1;
  localparam logic [2:0] RST_SAFETY_CURRENT_THRESHOLD = 3'h4;
  // Field positions in the 5-bit enable/current registers
  localparam int ENABLE_BIT = 4;
  // Current tables: flash in mA, torch in tenths of mA
  localparam logic [11:0] FLASH_MA_TOP = 12'h4b0;
  localparam logic [11:0] FLASH_MA_STEP = 12'h032;
  localparam logic [11:0] FLASH_MA_CODE14 = 12'h190;
  localparam logic [11:0] FLASH_MA_CODE15 = 12'h0fa;
  localparam logic [11:0] TORCH_TMA_TOP = 12'hbb8;
  localparam logic [11:0] TORCH_TMA_STEP = 12'h07d;
  localparam logic [11:0] TORCH_TMA_CODE14 = 12'h3e8;
  localparam logic [11:0] TORCH_TMA_CODE15 = 12'h271;
  // Safety threshold: 50 mA base plus 50 mA per code
  localparam logic [11:0] THRESH_MA_STEP = 12'h032;
  localparam logic [11:0] TENTHS_PER_MA = 12'h00a;
endpackage

/* rtl/flr_safety_timer.sv */
// Safety timer: counts while LED current is above threshold, latches expiry.
// Assumes clear is pulsed on each new flash/torch command and in shutdown.
`timescale 1ns/1ps
`default_nettype none
module flr_safety_timer #(
  parameter int CNT_W = 25,
  parameter int STEP_CYCLES = flr_pkg::SAFETY_STEP_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Control
  input wire logic clear,
  input wire logic run,
  input wire logic [2:0] duration_code,
  // Status
  output logic expired
);
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic next_expired;
  logic [CNT_W-1:0] limit;

  // Timeout is (code + 1) steps
  assign limit = CNT_W'((32'(duration_code) + 32'd1) * STEP_CYCLES - 1);

  always_comb begin
    next_count = count;
    next_expired = expired;
    // Expiry in the cycle of a clear still latches; the next command clears it
    if (run && !expired && (count >= limit)) begin
      next_expired = 1'b1;
    end else if (clear) begin
      next_count = '0;
      next_expired = 1'b0;
    end else if (run && !expired) begin
      next_count = count + 1'b1;
    end else if (!run) begin
      next_count = '0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
      expired <= 1'b0;
    end else begin
      count <= next_count;
      expired <= next_expired;
    end
  end
endmodule
`default_nettype wire

/* rtl/flr_control_regs.sv */
// Write-only control register set of a flash LED driver.
// Assumes a pulse decoder delivers each counted word and the frame stop.
`timescale 1ns/1ps
`default_nettype none
module flr_control_regs #(
  parameter int WORD_W = 6,
  parameter int SHUTDOWN_CYCLES = flr_pkg::SHUTDOWN_CYCLES,
  parameter int SAFETY_STEP_CYCLES = flr_pkg::SAFETY_STEP_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Serial link after pulse decoding
  input wire logic serial_control_pin,
  input wire logic word_strobe,
  input wire logic [WORD_W-1:0] word_value,
  input wire logic frame_end,
  // Analog side inputs
  input wire logic flash_trigger,
  input wire logic [3:0] supply_step,
  // Register contents
  output logic flash_enable_bit,
  output logic [3:0] flash_current_code,
  output logic torch_enable_bit,
  output logic [3:0] torch_current_code,
  output logic [2:0] safety_duration_code,
  output logic [3:0] battery_threshold_code,
  output logic [2:0] safety_current_threshold_code,
  // Status and drive
  output logic low_supply_detection,
  output logic flash_drive,
  output logic torch_drive,
  output logic shutdown,
  output logic frame_accepted,
  output logic frame_discarded
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_DATA = 5'h04,
    ST_OVER = 5'h08,
    ST_OFF  = 5'h10
  } flr_state_t;

  flr_state_t state;
  flr_state_t next_state;
  logic [WORD_W-1:0] addr_word;
  logic [WORD_W-1:0] data_word;
  logic [WORD_W-1:0] next_addr_word;
  logic [WORD_W-1:0] next_data_word;
  logic [13:0] low_count;
  logic [13:0] next_low_count;
  logic next_flash_enable_bit;
  logic [3:0] next_flash_current_code;
  logic next_torch_enable_bit;
  logic [3:0] next_torch_current_code;
  logic [2:0] next_safety_duration_code;
  logic [3:0] next_battery_threshold_code;
  logic [2:0] next_safety_current_threshold_code;
  logic next_low_supply_detection;
  logic next_flash_drive;
  logic next_torch_drive;
  logic next_shutdown;
  logic next_frame_accepted;
  logic next_frame_discarded;
  logic go_off;
  logic write_ok;
  logic [4:0] max_value;
  logic addr_valid;
  logic led_cmd;
  logic timer_clear;
  logic timer_run;
  logic timer_expired;
  logic [11:0] flash_ma;
  logic [11:0] torch_tma;
  logic [11:0] thresh_ma;

  // Flash current table in mA
  function automatic logic [11:0] flash_ma_of(input logic [3:0] code);
    logic [11:0] v;
    v = flr_pkg::FLASH_MA_TOP - 12'(flr_pkg::FLASH_MA_STEP * 12'(code));
    if (code == 4'he) v = flr_pkg::FLASH_MA_CODE14;
    if (code == 4'hf) v = flr_pkg::FLASH_MA_CODE15;
    return v;
  endfunction

  // Torch current table in tenths of mA
  function automatic logic [11:0] torch_tma_of(input logic [3:0] code);
    logic [11:0] v;
    v = flr_pkg::TORCH_TMA_TOP - 12'(flr_pkg::TORCH_TMA_STEP * 12'(code));
    if (code == 4'he) v = flr_pkg::TORCH_TMA_CODE14;
    if (code == 4'hf) v = flr_pkg::TORCH_TMA_CODE15;
    return v;
  endfunction

  assign flash_ma = flash_ma_of(flash_current_code);
  assign torch_tma = torch_tma_of(torch_current_code);
  assign thresh_ma = 12'(flr_pkg::THRESH_MA_STEP * 12'(safety_current_threshold_code + 3'h1));

  // Address decode and maximum value
  always_comb begin
    addr_valid = 1'b1;
    max_value = 5'h00;
    case (addr_word)
      WORD_W'(flr_pkg::ADDR_FLASH_CONTROL): max_value = flr_pkg::MAX_FLASH_CONTROL;
      WORD_W'(flr_pkg::ADDR_TORCH_CONTROL): max_value = flr_pkg::MAX_TORCH_CONTROL;
      WORD_W'(flr_pkg::ADDR_SAFETY_DURATION): max_value = flr_pkg::MAX_SAFETY_DURATION;
      WORD_W'(flr_pkg::ADDR_BATTERY_THRESHOLD): max_value = flr_pkg::MAX_BATTERY_THRESHOLD;
      WORD_W'(flr_pkg::ADDR_SAFETY_CURRENT_THRESHOLD): begin
        max_value = flr_pkg::MAX_SAFETY_CURRENT_THRESHOLD;
      end
      default: addr_valid = 1'b0;
    endcase
  end

  assign go_off = (low_count >= 14'(SHUTDOWN_CYCLES - 1)) && !serial_control_pin;
  assign write_ok = frame_end && (state == ST_DATA) && addr_valid &&
                    (data_word <= WORD_W'(max_value));

  // Frame sequencing and shutdown detection
  always_comb begin
    next_state = state;
    next_addr_word = addr_word;
    next_data_word = data_word;
    next_low_count = low_count;
    next_frame_accepted = 1'b0;
    next_frame_discarded = 1'b0;
    if (serial_control_pin || word_strobe) begin
      next_low_count = '0;
    end else if (!go_off) begin
      next_low_count = low_count + 14'h0001;
    end
    case (state)
      ST_OFF: begin
        if (serial_control_pin) next_state = ST_IDLE;
      end
      ST_IDLE, ST_ADDR, ST_DATA, ST_OVER: begin
        if (go_off) begin
          next_state = ST_OFF;
        end else if (frame_end) begin
          next_state = ST_IDLE;
          next_frame_accepted = write_ok;
          next_frame_discarded = !write_ok;
        end else if (word_strobe) begin
          case (state)
            ST_IDLE: begin
              next_state = ST_ADDR;
              next_addr_word = word_value;
            end
            ST_ADDR: begin
              next_state = ST_DATA;
              next_data_word = word_value;
            end
            default: next_state = ST_OVER;
          endcase
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // Register file, written on an accepted frame and loaded with reset values on shutdown
  always_comb begin
    next_flash_enable_bit = flash_enable_bit;
    next_flash_current_code = flash_current_code;
    next_torch_enable_bit = torch_enable_bit;
    next_torch_current_code = torch_current_code;
    next_safety_duration_code = safety_duration_code;
    next_battery_threshold_code = battery_threshold_code;
    next_safety_current_threshold_code = safety_current_threshold_code;
    led_cmd = 1'b0;
    if (go_off || state == ST_OFF) begin
      next_flash_enable_bit = flr_pkg::RST_FLASH_CONTROL[flr_pkg::ENABLE_BIT];
      next_flash_current_code = flr_pkg::RST_FLASH_CONTROL[3:0];
      next_torch_enable_bit = flr_pkg::RST_TORCH_CONTROL[flr_pkg::ENABLE_BIT];
      next_torch_current_code = flr_pkg::RST_TORCH_CONTROL[3:0];
      next_safety_duration_code = flr_pkg::RST_SAFETY_DURATION;
      next_battery_threshold_code = flr_pkg::RST_BATTERY_THRESHOLD;
      next_safety_current_threshold_code = flr_pkg::RST_SAFETY_CURRENT_THRESHOLD;
    end else if (write_ok) begin
      case (addr_word[2:0])
        flr_pkg::ADDR_FLASH_CONTROL: begin
          next_flash_enable_bit = data_word[flr_pkg::ENABLE_BIT];
          next_flash_current_code = data_word[3:0];
          led_cmd = 1'b1;
        end
        flr_pkg::ADDR_TORCH_CONTROL: begin
          next_torch_enable_bit = data_word[flr_pkg::ENABLE_BIT];
          next_torch_current_code = data_word[3:0];
          led_cmd = 1'b1;
        end
        flr_pkg::ADDR_SAFETY_DURATION: next_safety_duration_code = data_word[2:0];
        flr_pkg::ADDR_BATTERY_THRESHOLD: next_battery_threshold_code = data_word[3:0];
        flr_pkg::ADDR_SAFETY_CURRENT_THRESHOLD: begin
          next_safety_current_threshold_code = data_word[2:0];
        end
        default: led_cmd = 1'b0;
      endcase
    end
  end

  // Low battery and LED drive
  always_comb begin
    next_low_supply_detection = (battery_threshold_code != 4'h0) &&
                                (supply_step < battery_threshold_code);
    next_shutdown = (next_state == ST_OFF);
    next_flash_drive = (flash_enable_bit || flash_trigger) && !low_supply_detection &&
                       !timer_expired && !shutdown;
    next_torch_drive = torch_enable_bit && !timer_expired && !shutdown;
  end

  assign timer_clear = led_cmd || shutdown;
  assign timer_run = (safety_current_threshold_code != 3'h0) &&
                     ((flash_drive && flash_ma > thresh_ma) ||
                      (torch_drive && torch_tma > 12'(thresh_ma * flr_pkg::TENTHS_PER_MA)));

  flr_safety_timer #(
    .CNT_W(25),
    .STEP_CYCLES(SAFETY_STEP_CYCLES)
  ) u_timer (
    .clk(clk),
    .arst_n(arst_n),
    .clear(timer_clear),
    .run(timer_run),
    .duration_code(safety_duration_code),
    .expired(timer_expired)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      addr_word <= '0;
      data_word <= '0;
      low_count <= '0;
      flash_enable_bit <= flr_pkg::RST_FLASH_CONTROL[flr_pkg::ENABLE_BIT];
      flash_current_code <= flr_pkg::RST_FLASH_CONTROL[3:0];
      torch_enable_bit <= flr_pkg::RST_TORCH_CONTROL[flr_pkg::ENABLE_BIT];
      torch_current_code <= flr_pkg::RST_TORCH_CONTROL[3:0];
      safety_duration_code <= flr_pkg::RST_SAFETY_DURATION;
      battery_threshold_code <= flr_pkg::RST_BATTERY_THRESHOLD;
      safety_current_threshold_code <= flr_pkg::RST_SAFETY_CURRENT_THRESHOLD;
      low_supply_detection <= 1'b0;
      flash_drive <= 1'b0;
      torch_drive <= 1'b0;
      shutdown <= 1'b0;
      frame_accepted <= 1'b0;
      frame_discarded <= 1'b0;
    end else begin
      state <= next_state;
      addr_word <= next_addr_word;
      data_word <= next_data_word;
      low_count <= next_low_count;
      flash_enable_bit <= next_flash_enable_bit;
      flash_current_code <= next_flash_current_code;
      torch_enable_bit <= next_torch_enable_bit;
      torch_current_code <= next_torch_current_code;
      safety_duration_code <= next_safety_duration_code;
      battery_threshold_code <= next_battery_threshold_code;
      safety_current_threshold_code <= next_safety_current_threshold_code;
      low_supply_detection <= next_low_supply_detection;
      flash_drive <= next_flash_drive;
      torch_drive <= next_torch_drive;
      shutdown <= next_shutdown;
      frame_accepted <= next_frame_accepted;
      frame_discarded <= next_frame_discarded;
    end
  end
endmodule
`default_nettype wire

/* tb/flr_host.sv */
// Host model: hands decoded words, frame stops and the control pin level to the block.
// Assumes its tasks are entered just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module flr_host (
  // Clock
  input wire logic clk,
  // Decoded serial link
  output var logic serial_control_pin,
  output var logic word_strobe,
  output var logic [5:0] word_value,
  output var logic frame_end
);
  initial begin
    serial_control_pin = 1'b1;
    word_strobe = 1'b0;
    word_value = 6'h2a;
    frame_end = 1'b0;
  end
  // Address word first, then data words, then the stop; n words in all
  task automatic send(input logic [5:0] a, input logic [5:0] d, input int n);
    for (int i = 0; i < n; i++) begin
      word_strobe = 1'b1;
      word_value = (i == 0) ? a : d;
      @(posedge clk);
      #1;
    end
    word_strobe = 1'b0;
    word_value = ~word_value;
    frame_end = 1'b1;
    @(posedge clk);
    #1;
    frame_end = 1'b0;
  endtask
  // Pin held low with no words, then released high
  task automatic pin_low(input int cycles);
    serial_control_pin = 1'b0;
    repeat (cycles) @(posedge clk);
    #1;
    serial_control_pin = 1'b1;
  endtask
endmodule
`default_nettype wire

/* tb/flr_regs_sva.sv */
// Checker for the flash LED control register set.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module flr_regs_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Inputs
  input wire logic serial_control_pin,
  input wire logic frame_end,
  input wire logic flash_trigger,
  input wire logic [3:0] supply_step,
  // Register contents
  input wire logic flash_enable_bit,
  input wire logic [3:0] flash_current_code,
  input wire logic torch_enable_bit,
  input wire logic [3:0] torch_current_code,
  input wire logic [2:0] safety_duration_code,
  input wire logic [3:0] battery_threshold_code,
  input wire logic [2:0] safety_current_threshold_code,
  // Status
  input wire logic low_supply_detection,
  input wire logic flash_drive,
  input wire logic torch_drive,
  input wire logic shutdown,
  input wire logic frame_accepted,
  input wire logic frame_discarded
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic [19:0] regs;
  assign regs = {flash_enable_bit, flash_current_code, torch_enable_bit, torch_current_code,
    safety_duration_code, battery_threshold_code, safety_current_threshold_code};
  a_one_verdict: assert property (!(frame_accepted && frame_discarded))
    else $error("accept and discard together");
  a_verdict_on_end: assert property (frame_accepted || frame_discarded |-> $past(frame_end))
    else $error("verdict without frame stop");
  a_regs_hold: assert property ($changed(regs) |-> frame_accepted || shutdown)
    else $error("registers changed without accepted frame");
  a_shut_defaults: assert property (shutdown |-> regs == 20'h0038c)
    else $error("registers not default in shutdown");
  a_wake_on_high: assert property (shutdown && serial_control_pin |=> !shutdown)
    else $error("shutdown kept with pin high");
  a_shut_drives_off: assert property (shutdown && $past(shutdown) |-> !flash_drive && !torch_drive)
    else $error("drive on in shutdown");
  a_flash_cause: assert property ($rose(flash_drive) |-> $past(flash_enable_bit || flash_trigger))
    else $error("flash drive without enable or trigger");
  a_torch_enable: assert property (torch_drive |-> $past(torch_enable_bit))
    else $error("torch drive without enable");
  a_low_supply: assert property (low_supply_detection == $past(battery_threshold_code != 4'h0 &&
    supply_step < battery_threshold_code))
    else $error("low supply flag wrong");
endmodule
bind flr_control_regs flr_regs_sva u_sva (.clk, .arst_n, .serial_control_pin, .frame_end,
  .flash_trigger, .supply_step, .flash_enable_bit, .flash_current_code, .torch_enable_bit,
  .torch_current_code, .safety_duration_code, .battery_threshold_code,
  .safety_current_threshold_code, .low_supply_detection, .flash_drive, .torch_drive,
  .shutdown, .frame_accepted, .frame_discarded);
`default_nettype wire

/* tb/tb.sv */
// Testbench for the flash LED control register set.
// Assumes the host model drives the decoded serial link.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic flash_trigger = 1'b0;
  logic [3:0] supply_step = 4'h9;
  logic serial_control_pin, word_strobe, frame_end;
  logic [5:0] word_value;
  logic flash_enable_bit, torch_enable_bit, low_supply_detection, flash_drive, torch_drive;
  logic shutdown, frame_accepted, frame_discarded;
  logic [3:0] flash_current_code, torch_current_code, battery_threshold_code;
  logic [2:0] safety_duration_code, safety_current_threshold_code;
  logic [4:0] e [1:5];
  logic [5:0] mx [1:5] = '{6'h1f, 6'h1f, 6'h07, 6'h09, 6'h05};
  int fails = 0;
  int checked = 0;
  always #25 clk = ~clk;
  flr_host host (.clk, .serial_control_pin, .word_strobe, .word_value, .frame_end);
  flr_control_regs #(.WORD_W(6), .SHUTDOWN_CYCLES(20), .SAFETY_STEP_CYCLES(10)) DUT (.clk,
    .arst_n, .serial_control_pin, .word_strobe, .word_value, .frame_end, .flash_trigger,
    .supply_step, .flash_enable_bit, .flash_current_code, .torch_enable_bit,
    .torch_current_code, .safety_duration_code, .battery_threshold_code,
    .safety_current_threshold_code, .low_supply_detection, .flash_drive, .torch_drive,
    .shutdown, .frame_accepted, .frame_discarded);
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_regs();
    chk({flash_enable_bit, flash_current_code, torch_enable_bit, torch_current_code,
      safety_duration_code, battery_threshold_code, safety_current_threshold_code},
      {e[1], e[2], e[3][2:0], e[4][3:0], e[5][2:0]});
  endtask
  task automatic wr(input logic [5:0] a, input logic [5:0] d, input int n);
    bit ok;
    ok = n == 2 && a >= 6'h01 && a <= 6'h05 && d <= mx[a[2:0]];
    host.send(a, d, n);
    chk(20'({frame_accepted, frame_discarded}), ok ? 20'h2 : 20'h1);
    if (ok) e[a[2:0]] = d[4:0];
    chk_regs();
  endtask
  task automatic results();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  initial begin
    e = '{5'h00, 5'h00, 5'h07, 5'h01, 5'h04};
    step(3);
    arst_n = 1'b1;
    chk_regs();
    $display("test reset done");
    wr(6'h01, 6'h14, 2);
    wr(6'h01, 6'h05, 2);
    wr(6'h01, 6'h20, 2);
    wr(6'h02, 6'h1f, 2);
    step(1);
    chk(20'(torch_drive), 20'h1);
    wr(6'h02, 6'h03, 2);
    step(1);
    chk(20'(torch_drive), 20'h0);
    wr(6'h03, 6'h00, 2);
    wr(6'h03, 6'h08, 2);
    wr(6'h04, 6'h09, 2);
    wr(6'h04, 6'h0a, 2);
    wr(6'h05, 6'h05, 2);
    wr(6'h05, 6'h06, 2);
    wr(6'h00, 6'h01, 2);
    wr(6'h06, 6'h01, 2);
    wr(6'h01, 6'h10, 1);
    wr(6'h01, 6'h10, 3);
    $display("test frames done");
    wr(6'h04, 6'h01, 2);
    flash_trigger = 1'b1;
    step(2);
    chk(20'(flash_drive), 20'h1);
    flash_trigger = 1'b0;
    host.pin_low(25);
    e = '{5'h00, 5'h00, 5'h07, 5'h01, 5'h04};
    chk(20'(shutdown), 20'h1);
    chk_regs();
    step(1);
    chk(20'(shutdown), 20'h0);
    $display("test shutdown done");
    wr(6'h05, 6'h01, 2);
    wr(6'h03, 6'h00, 2);
    wr(6'h01, 6'h10, 2);
    step(2);
    chk(20'(flash_drive), 20'h1);
    step(15);
    chk(20'(flash_drive), 20'h0);
    wr(6'h05, 6'h00, 2);
    wr(6'h01, 6'h10, 2);
    step(20);
    chk(20'(flash_drive), 20'h1);
    $display("test timer done");
    wr(6'h04, 6'h09, 2);
    supply_step = 4'h5;
    step(3);
    chk(20'({low_supply_detection, flash_drive}), 20'h2);
    wr(6'h04, 6'h00, 2);
    step(2);
    chk(20'(low_supply_detection), 20'h0);
    $display("test battery done");
    arst_n = 1'b0;
    step(2);
    arst_n = 1'b1;
    e = '{5'h00, 5'h00, 5'h07, 5'h01, 5'h04};
    chk_regs();
    chk(20'({flash_drive, torch_drive, shutdown}), 20'h0);
    $display("test mid reset done");
    wr(6'h03, 6'h00, 2);
    wr(6'h05, 6'h05, 2);
    wr(6'h01, 6'h1e, 2);
    step(15);
    chk(20'(flash_drive), 20'h0);
    wr(6'h01, 6'h1f, 2);
    step(20);
    chk(20'(flash_drive), 20'h1);
    wr(6'h01, 6'h00, 2);
    wr(6'h05, 6'h01, 2);
    wr(6'h02, 6'h1d, 2);
    step(15);
    chk(20'(torch_drive), 20'h0);
    wr(6'h02, 6'h1e, 2);
    step(20);
    chk(20'(torch_drive), 20'h1);
    $display("test tables done");
    results();
  end
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    results();
  end
endmodule
`default_nettype wire
